// [include/seep_pkg.sv]
/*
  shared constants for the two-wire serial eeprom slave: array geometry,
  bus selection code, page buffer depth, state encoding and programming time.
  assumes a 250 mhz system clock that oversamples the bus pins.
*/
package seep_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned PAGE_BITS = 4;
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned PROG_TIME_US = 5000;
  // longest time: exact product of 5000 us and 250 cycles per us, no rounding
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned PROG_CNT_W = 21;
  typedef enum logic [2:0] {
    SEEP_IDLE = 3'b000,
    SEEP_DEVSEL = 3'b001,
    SEEP_WADDR = 3'b011,
    SEEP_WDATA = 3'b010,
    SEEP_RDATA = 3'b110,
    SEEP_PROG = 3'b111,
    SEEP_IGNORE = 3'b101
  } seep_state_e;
endpackage

// [hw/seep_fifo.sv]
/*
  small synchronous fifo of flip-flops, valid and ready on both sides.
  assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module seep_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_mclk,               // system clock
  input wire logic i_rst_n,              // sync reset, low active
  input wire logic i_flush,              // drop all content
  input wire logic i_in_valid,           // write request
  output logic o_in_ready,               // room available
  input wire logic [WIDTH-1:0] i_in_data, // write word
  output logic o_out_valid,              // word available
  input wire logic i_out_ready,          // read request
  output logic [WIDTH-1:0] o_out_data    // head word
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] cnt_r;
  logic push;
  logic pop;
  assign o_in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data = mem_r[rp_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem_r[wp_r] <= i_in_data;
    end
  end
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || i_flush)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
      begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [hw/seep_top.sv]
/*
  two-wire serial eeprom slave: bit engine, byte sequencer, page buffer,
  self-timed programming and flip-flop array.
  assumes bus pins asynchronous to i_mclk and well below its rate;
  i_rst_n stands for the internal power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none
module seep_top #(
  parameter int unsigned PROG_CYCLES = seep_pkg::PROG_CYCLES
) (
  input wire logic i_mclk,               // 250 mhz clock
  input wire logic i_rst_n,              // power-on reset, low active
  input wire logic i_scl,                // bus clock from master
  input wire logic i_sda,                // bus data level
  output logic o_sda,                    // bus data drive value (always 0)
  output logic o_sda_oe_n,               // low: pull data line low
  input wire logic i_wp,                 // write protect
  input wire logic i_address_select_bit0, // select pin 0
  input wire logic i_address_select_bit1, // select pin 1
  input wire logic i_address_select_bit2, // select pin 2
  output logic o_busy                    // programming in progress
);
  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  logic [2:0] scl_sr;
  logic [2:0] sda_sr;
  logic [2:0] sel_sr [3];
  logic [2:0] wp_sr;
  logic scl_r;
  logic sda_r;
  always_ff @(posedge i_mclk)
  begin
    scl_sr <= {scl_sr[1:0], i_scl};
    sda_sr <= {sda_sr[1:0], i_sda};
    wp_sr <= {wp_sr[1:0], i_wp};
    sel_sr[0] <= {sel_sr[0][1:0], i_address_select_bit0};
    sel_sr[1] <= {sel_sr[1][1:0], i_address_select_bit1};
    sel_sr[2] <= {sel_sr[2][1:0], i_address_select_bit2};
  end
  // a level change counts once stages two and three agree
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end
    else
    begin
      if (scl_sr[1] == scl_sr[2])
      begin
        scl_r <= scl_sr[2];
      end
      if (sda_sr[1] == sda_sr[2])
      begin
        sda_r <= sda_sr[2];
      end
    end
  end
  logic scl_d;
  logic sda_d;
  always_ff @(posedge i_mclk)
  begin
    scl_d <= scl_r;
    sda_d <= sda_r;
  end
  wire scl_rise = scl_r && !scl_d;
  wire scl_fall = !scl_r && scl_d;
  wire start_ev = scl_r && scl_d && sda_d && !sda_r;
  wire stop_ev = scl_r && scl_d && !sda_d && sda_r;
  wire [2:0] sel_pins = {sel_sr[2][2], sel_sr[1][2], sel_sr[0][2]};
  wire wp_hi = wp_sr[2];

  // ------------------------------------------------------------
  // state and byte engine
  // ------------------------------------------------------------
  seep_pkg::seep_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic ack_phase_r;
  logic ack_drv_r;
  localparam int unsigned PROG_CNT_W_L = seep_pkg::PROG_CNT_W;
  logic [PROG_CNT_W_L-1:0] prog_cnt_r;
  logic [7:0] mem_r [seep_pkg::MEM_DEPTH];

  function automatic logic sel_match(input logic [7:0] b, input logic [2:0] pins);
    sel_match = (b[7:4] == seep_pkg::DEV_CODE) && (b[3:1] == pins);
  endfunction

  wire byte_done = scl_rise && (bit_cnt_r == 4'h7) && !ack_phase_r;
  wire [7:0] byte_val = {shift_r[6:0], sda_r};

  // page buffer: words {low address, data}
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [11:0] fifo_out_data;
  logic fifo_flush;
  logic [7:0] page_base_r;
  // the countdown runs on while the buffer drains, so the bytes add no time
  wire prog_done = (state_r == seep_pkg::SEEP_PROG) && (prog_cnt_r == '0) && !fifo_out_valid;

  // byte received in data phase goes to the page buffer; bytes beyond
  // sixteen are dropped rather than rolled over, a known limitation
  assign fifo_in_valid = byte_done && (state_r == seep_pkg::SEEP_WDATA) && fifo_in_ready;
  assign fifo_out_ready = (state_r == seep_pkg::SEEP_PROG);
  // a new frame from standby drops bytes left by a refused protected write
  assign fifo_flush = (state_r == seep_pkg::SEEP_IDLE) && start_ev;

  seep_fifo #(
    .WIDTH(12),
    .DEPTH(seep_pkg::FIFO_DEPTH)
  ) u_page (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_flush(fifo_flush),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data({ptr_r[3:0], byte_val}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      state_r <= seep_pkg::SEEP_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ack_phase_r <= 1'b0;
      ack_drv_r <= 1'b0;
      ptr_r <= 8'h00;
      page_base_r <= 8'h00;
      prog_cnt_r <= '0;
    end
    else if (state_r == seep_pkg::SEEP_PROG)
    begin
      // bus ignored entirely while programming
      ack_drv_r <= 1'b0;
      if (prog_cnt_r != '0)
      begin
        prog_cnt_r <= prog_cnt_r - 1'b1;
      end
      if (prog_done)
      begin
        state_r <= seep_pkg::SEEP_IDLE;
      end
    end
    else if (stop_ev)
    begin
      ack_drv_r <= 1'b0;
      // program only what was received, never under protect
      if (state_r == seep_pkg::SEEP_WDATA && fifo_out_valid && !wp_hi)
      begin
        state_r <= seep_pkg::SEEP_PROG;
        prog_cnt_r <= PROG_CNT_W_L'(PROG_CYCLES - 1);
      end
      else
      begin
        state_r <= seep_pkg::SEEP_IDLE;
      end
    end
    else if (start_ev)
    begin
      state_r <= seep_pkg::SEEP_DEVSEL;
      bit_cnt_r <= 4'h0;
      ack_phase_r <= 1'b0;
      ack_drv_r <= 1'b0;
    end
    else if (state_r != seep_pkg::SEEP_IDLE && state_r != seep_pkg::SEEP_IGNORE)
    begin
      if (scl_rise && !ack_phase_r)
      begin
        shift_r <= byte_val;
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end
      if (byte_done)
      begin
        ack_phase_r <= 1'b1;
        bit_cnt_r <= 4'h0;
        unique case (state_r)
          seep_pkg::SEEP_DEVSEL:
          begin
            if (sel_match(byte_val, sel_pins))
            begin
              state_r <= byte_val[0] ? seep_pkg::SEEP_RDATA : seep_pkg::SEEP_WADDR;
            end
            else
            begin
              state_r <= seep_pkg::SEEP_IGNORE;
            end
          end
          seep_pkg::SEEP_WADDR:
          begin
            ptr_r <= byte_val;
            page_base_r <= byte_val;
            state_r <= seep_pkg::SEEP_WDATA;
          end
          seep_pkg::SEEP_WDATA:
          begin
            ptr_r <= {ptr_r[7:4], ptr_r[3:0] + 4'h1};
          end
          default:
          begin
          end
        endcase
      end
      if (scl_fall && ack_phase_r && !ack_drv_r)
      begin
        ack_drv_r <= 1'b1; // own the ninth bit
      end
      else if (scl_fall && ack_drv_r)
      begin
        ack_drv_r <= 1'b0;
        ack_phase_r <= 1'b0;
        if (state_r == seep_pkg::SEEP_RDATA)
        begin
          // read data is not served: let go of the bus until the next start
          state_r <= seep_pkg::SEEP_IGNORE;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // array write on drain of the page buffer
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (fifo_out_ready && fifo_out_valid && !wp_hi)
    begin
      mem_r[{page_base_r[7:4], fifo_out_data[11:8]}] <= fifo_out_data[7:0];
    end
  end

  // the line is only ever pulled low, for acknowledge
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_sda_oe_n <= 1'b1;
      o_sda <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      o_sda <= 1'b0;
      o_sda_oe_n <= !(ack_drv_r && state_r != seep_pkg::SEEP_PROG);
      o_busy <= (state_r == seep_pkg::SEEP_PROG);
    end
  end
endmodule
`default_nettype wire

// [tb/seep_checker.sv]
/*
  port checker for seep_top, bound to every instance.
  assumes one clock domain and a bus far slower than i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module seep_checker #(
  parameter int unsigned PROG_CYCLES = 100
) (
  input wire logic i_mclk,                // system clock
  input wire logic i_rst_n,               // power-on reset
  input wire logic i_scl,                 // bus clock
  input wire logic i_sda,                 // bus data
  input wire logic o_sda,                 // drive value
  input wire logic o_sda_oe_n,            // pull enable
  input wire logic i_wp,                  // write protect
  input wire logic i_address_select_bit0, // select pin 0
  input wire logic i_address_select_bit1, // select pin 1
  input wire logic i_address_select_bit2, // select pin 2
  input wire logic o_busy                 // programming
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  logic [31:0] busy_cnt_r;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || !o_busy)
      busy_cnt_r <= 32'h0;
    else
      busy_cnt_r <= busy_cnt_r + 32'h1;
  end
  property p_rel;
    $rose(i_rst_n) |-> o_sda_oe_n && !o_busy;
  endproperty
  a_rel: assert property (p_rel) else $error("outputs active out of reset");
  property p_low;
    o_sda == 1'b0;
  endproperty
  a_low: assert property (p_low) else $error("data drive value not low");
  property p_quiet;
    o_busy |-> o_sda_oe_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("ack while programming");
  property p_max;
    busy_cnt_r <= PROG_CYCLES;
  endproperty
  a_max: assert property (p_max) else $error("programming too long");
  property p_min;
    $fell(o_busy) |-> busy_cnt_r + 32'h2 >= PROG_CYCLES;
  endproperty
  a_min: assert property (p_min) else $error("programming cut short");
  property p_ackl;
    $fell(o_sda_oe_n) |-> !i_scl ##1 !o_sda_oe_n [*8];
  endproperty
  a_ackl: assert property (p_ackl) else $error("ack badly placed");
  property p_ackr;
    !o_sda_oe_n |-> ##[1:40] o_sda_oe_n;
  endproperty
  a_ackr: assert property (p_ackr) else $error("ack not released");
  property p_wp;
    $rose(o_busy) |-> !$past(i_wp, 4);
  endproperty
  a_wp: assert property (p_wp) else $error("programming while protected");
  property p_stop;
    $rose(o_busy) |-> i_scl && i_sda;
  endproperty
  a_stop: assert property (p_stop) else $error("programming without stop");
endmodule
bind seep_top seep_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_wp(i_wp),
  .i_address_select_bit0(i_address_select_bit0), .i_address_select_bit1(i_address_select_bit1),
  .i_address_select_bit2(i_address_select_bit2), .o_busy(o_busy));
`default_nettype wire

// [tb/seep_master.sv]
/*
  two-wire bus master model: 64 ns bus clock, idle high between frames.
  assumes the data line is pulled up where nobody pulls it low.
*/
`timescale 1ns/1ps
`default_nettype none
module seep_master (
  input wire logic i_mclk, // system clock
  input wire logic i_sda,  // resolved data line
  output logic o_scl,      // bus clock
  output logic o_sda       // low pulls the line
);
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic start();
    o_sda <= 1'b0;
    wt(8);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    wt(4);
    o_sda <= 1'b0;
    wt(4);
    o_scl <= 1'b1;
    wt(8);
    o_sda <= 1'b1;
    // short free time, so a caller still sees the busy flag rise
    wt(4);
  endtask
  // data moves mid-low so it never changes while the clock is high
  task automatic put_bit(input logic b, output logic s);
    wt(4);
    o_sda <= b;
    wt(4);
    o_scl <= 1'b1;
    wt(8);
    s = i_sda;
    o_scl <= 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask
endmodule
`default_nettype wire

// [tb/seep_top_tb_top.sv]
/*
  testbench for seep_top: select, page writes, protect, busy and reset.
  assumes a shortened programming time set through PROG_CYCLES.
*/
`timescale 1ns/1ps
`default_nettype none
module seep_top_tb_top;
  localparam int PROG = 1000;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wp = 1'b0;
  logic scl;
  logic m_sda;
  logic o_sda;
  logic o_sda_oe_n;
  logic o_busy;
  logic sda_line;
  logic [7:0] dev_w;
  logic [2:0] sel = 3'h5;
  int miscompares = 0;
  int tests_run = 0;
  assign sda_line = m_sda & (o_sda_oe_n | o_sda);
  assign dev_w = {seep_pkg::DEV_CODE, sel, 1'b0};
  initial
  begin
    forever #2 i_mclk = ~i_mclk;
  end
  seep_master mst (.i_mclk(i_mclk), .i_sda(sda_line), .o_scl(scl), .o_sda(m_sda));
  seep_top #(.PROG_CYCLES(PROG)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_line),
    .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_wp(i_wp), .i_address_select_bit0(sel[0]),
    .i_address_select_bit1(sel[1]), .i_address_select_bit2(sel[2]), .o_busy(o_busy));
  task automatic chk(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic t_select();
    logic a;
    for (int p = 2; p < 8; p += 3)
    begin
      sel <= p[2:0];
      for (int s = 0; s < 8; s++)
      begin
        mst.start();
        mst.put_byte({seep_pkg::DEV_CODE, s[2:0], s[0]}, a);
        chk(a, s[2:0] == p[2:0], "select ack");
        mst.stop();
        mst.wt(PROG + 50);
      end
    end
    sel <= 3'h5;
    $display("select test done");
  endtask
  // busy span is counted after stop; protected writes must not program
  task automatic t_page(input logic [7:0] addr, input int n, input logic wp);
    logic a;
    int cnt;
    logic [7:0] wa;
    i_wp <= wp;
    mst.start();
    mst.put_byte(dev_w, a);
    chk(a, 1'b1, "device ack");
    mst.put_byte(addr, a);
    chk(a, 1'b1, "address ack");
    for (int i = 0; i < n; i++)
    begin
      mst.put_byte(8'h5a ^ i[7:0], a);
      chk(a, 1'b1, "data ack");
    end
    mst.stop();
    cnt = 0;
    repeat (PROG + 50) @(posedge i_mclk) cnt += (o_busy === 1'b1);
    chk(cnt >= PROG && cnt <= PROG + 8, !wp, "busy span");
    for (int i = 0; i < n; i++)
    begin
      wa = {addr[7:4], addr[3:0] + i[3:0]};
      if (wp)
        chk(dut.mem_r[wa] === (8'h5a ^ i[7:0]), 1'b0, "protected byte");
      else
        chk8(dut.mem_r[wa], 8'h5a ^ i[7:0], "array byte");
    end
    i_wp <= 1'b0;
    $display("page test done");
  endtask
  task automatic t_busy_reset();
    logic a;
    t_page_start();
    mst.start();
    mst.put_byte(dev_w, a);
    chk(a, 1'b0, "ack while busy");
    mst.stop();
    i_rst_n <= 1'b0;
    mst.wt(3);
    chk(o_busy, 1'b0, "busy after reset");
    mst.start();
    mst.put_byte(dev_w, a);
    chk(a, 1'b0, "ack in reset");
    mst.stop();
    i_rst_n <= 1'b1;
    mst.wt(8);
    mst.start();
    mst.put_byte(dev_w, a);
    chk(a, 1'b1, "ack after reset");
    mst.stop();
    $display("busy and reset test done");
  endtask
  task automatic t_page_start();
    logic a;
    mst.start();
    mst.put_byte(dev_w, a);
    mst.put_byte(8'h10, a);
    mst.put_byte(8'hc3, a);
    mst.stop();
    mst.wt(10);
    chk(o_busy, 1'b1, "busy after stop");
  endtask
  initial
  begin
    mst.wt(12);
    i_rst_n <= 1'b1;
    mst.wt(8);
    t_select();
    t_page(8'h3e, 16, 1'b0);
    t_page(8'hfe, 3, 1'b0);
    t_page(8'h30, 2, 1'b1);
    t_busy_reset();
    give_verdict();
  end
  initial
  begin
    repeat (60000) @(posedge i_mclk);
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
